// File: hdl/adc_output_latency_powerdown.sv
// Converter output stage: offset-binary coding, fixed latency, hi-z and power-down control
//
// How it works
// - Output word appears five cycles after sampling.
// - Offset binary: full scale ones, minus zeros.
// - Midscale gives MSB only; one step below gives 0x1FF.
// - Output disable high floats all data pins.
// - Output disable low drives data pins normally.
// - Power-down high enters reduced power state.
// - Undriven power-down means normal operation; no pull-down is modelled, so an open pin reads unknown.
// - Power-down floats outputs regardless of disable.
// - Five words after power-down release invalid.
// - One new sample and word every clock.
`timescale 1ns/1ps
`default_nettype none
module adc_output_latency_powerdown (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [adc_out_pkg::WORD_W-1:0] sample_in,
  input wire logic output_disable,
  input wire logic power_down,
  output logic [adc_out_pkg::WORD_W-1:0] data_out,
  output logic data_out_en,
  output logic data_valid,
  output logic low_power
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [adc_out_pkg::WORD_W-1:0] pipe_ff [adc_out_pkg::LATENCY];
  logic [adc_out_pkg::LATENCY-1:0] pipe_vld_ff;
  logic [adc_out_pkg::WORD_W-1:0] offset_binary_code;
  logic [2:0] ctrl_ff;
  logic overrun_ff;
  logic [2:0] rec_cnt_ff;
  logic [31:0] prdata_ff;
  logic [adc_out_pkg::WORD_W-1:0] last_word_ff;
  logic pd_act;
  logic od_act;
  logic recovering;
  logic apb_setup;
  logic apb_access;
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;
  logic [31:0] nxt_prdata;
  logic cap_valid;
  logic cap_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [adc_out_pkg::WORD_W-1:0] fifo_out_data;
  logic fifo_full;
  logic fifo_empty;
  logic ovr_set;
  logic ovr_clr;

  // ----------------------------------------------------------------
  // Pin and register control
  // ----------------------------------------------------------------
  // An open pin reads as unknown here; nothing stands in for the on-chip pull-downs
  assign pd_act = power_down || ctrl_ff[adc_out_pkg::CTRL_PD_BIT];
  assign od_act = output_disable || ctrl_ff[adc_out_pkg::CTRL_OD_BIT];
  assign low_power = pd_act;

  // Power-down wins over output disable, so no test setting can drive the bus while powered down
  assign data_out_en = !pd_act && !od_act;

  // ----------------------------------------------------------------
  // Coding and pipeline
  // ----------------------------------------------------------------
  // The quantizer delivers a two's complement value around midscale
  assign offset_binary_code = {~sample_in[adc_out_pkg::WORD_W-1], sample_in[adc_out_pkg::WORD_W-2:0]};

  // Data shifts on every edge, so one sample enters and one word leaves per clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe_ff[0] <= adc_out_pkg::WORD_RESET;
    end else begin
      pipe_ff[0] <= offset_binary_code;
    end
  end

  for (genvar g = 1; g < adc_out_pkg::LATENCY; g++) begin : g_stage
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pipe_ff[g] <= adc_out_pkg::WORD_RESET;
      end else begin
        pipe_ff[g] <= pipe_ff[g-1];
      end
    end
  end

  // Samples taken during power-down carry no valid mark; after release the marks
  // refill from the front, so the first valid word needs the full pipeline depth
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe_vld_ff <= '0;
    end else if (pd_act) begin
      pipe_vld_ff <= '0;
    end else begin
      pipe_vld_ff <= {pipe_vld_ff[adc_out_pkg::LATENCY-2:0], 1'b1};
    end
  end

  assign data_out = pipe_ff[adc_out_pkg::LATENCY-1];
  assign data_valid = pipe_vld_ff[adc_out_pkg::LATENCY-1];

  // Status only: counts down the cycles of invalid words after a release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_cnt_ff <= '0;
    end else if (pd_act) begin
      rec_cnt_ff <= adc_out_pkg::REC_CNT_INIT;
    end else if (rec_cnt_ff != '0) begin
      rec_cnt_ff <= rec_cnt_ff - 1'b1;
    end
  end

  assign recovering = !pd_act && (rec_cnt_ff != '0);

  // ----------------------------------------------------------------
  // Capture FIFO
  // ----------------------------------------------------------------
  // Only valid words are captured; when software falls behind the FIFO
  // refuses them and the overrun flag records the loss
  assign cap_valid = data_valid && ctrl_ff[adc_out_pkg::CTRL_CAP_BIT];
  assign ovr_set = cap_valid && !cap_ready;

  capture_fifo #(
    .WIDTH(adc_out_pkg::WORD_W),
    .DEPTH(adc_out_pkg::FIFO_DEPTH)
  ) i_capture_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(cap_valid),
    .in_ready(cap_ready),
    .in_data(data_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_word_ff <= adc_out_pkg::WORD_RESET;
    end else if (data_valid) begin
      last_word_ff <= data_out;
    end
  end

  property p_capture_push;
    @(posedge pclk) disable iff (!presetn) cap_valid && cap_ready |=> !fifo_empty;
  endproperty
  a_capture_push: assert property (p_capture_push) else $error("accepted word not held in fifo");

  property p_last_word;
    @(posedge pclk) disable iff (!presetn) data_valid |=> last_word_ff == $past(data_out);
  endproperty
  a_last_word: assert property (p_last_word) else $error("last word register missed a valid word");

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable;
  assign apb_wr = apb_access && pwrite && addr_ok;
  assign apb_rd = apb_access && !pwrite;
  assign pready = 1'b1;
  assign pslverr = apb_access && !addr_ok;
  assign prdata = prdata_ff;
  assign ovr_clr = apb_wr && (paddr == adc_out_pkg::OFS_STATUS) && pwdata[adc_out_pkg::ST_OVR_BIT];

  // Pop only a word that the setup cycle already put on prdata, so a push
  // landing between setup and access is never lost
  assign fifo_pop = apb_rd && (paddr == adc_out_pkg::OFS_DATA) && prdata_ff[adc_out_pkg::DATA_VALID_BIT];

  always_comb begin
    addr_ok = 1'b0;
    nxt_prdata = adc_out_pkg::PRDATA_RESET;
    if (paddr == adc_out_pkg::OFS_CTRL) begin
      addr_ok = 1'b1;
      nxt_prdata[2:0] = ctrl_ff;
    end else if (paddr == adc_out_pkg::OFS_STATUS) begin
      addr_ok = 1'b1;
      nxt_prdata[adc_out_pkg::ST_PD_BIT] = pd_act;
      nxt_prdata[adc_out_pkg::ST_REC_BIT] = recovering;
      nxt_prdata[adc_out_pkg::ST_VALID_BIT] = data_valid;
      nxt_prdata[adc_out_pkg::ST_EMPTY_BIT] = fifo_empty;
      nxt_prdata[adc_out_pkg::ST_FULL_BIT] = fifo_full;
      nxt_prdata[adc_out_pkg::ST_OVR_BIT] = overrun_ff;
    end else if (paddr == adc_out_pkg::OFS_DATA) begin
      addr_ok = 1'b1;
      nxt_prdata[adc_out_pkg::DATA_VALID_BIT] = fifo_out_valid;
      nxt_prdata[adc_out_pkg::WORD_W-1:0] = fifo_out_valid ? fifo_out_data : adc_out_pkg::WORD_RESET;
    end else if (paddr == adc_out_pkg::OFS_LAST) begin
      addr_ok = 1'b1;
      nxt_prdata[adc_out_pkg::WORD_W-1:0] = last_word_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= adc_out_pkg::PRDATA_RESET;
    end else if (apb_setup && !pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end

  property p_read_data;
    @(posedge pclk) disable iff (!presetn)
      apb_access && !pwrite && $past(apb_setup) |-> prdata == $past(nxt_prdata);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not the word chosen in setup");

  property p_pop_has_word;
    @(posedge pclk) disable iff (!presetn) fifo_pop |-> fifo_out_valid;
  endproperty
  a_pop_has_word: assert property (p_pop_has_word) else $error("fifo popped while empty");

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= adc_out_pkg::CTRL_RESET;
    end else if (apb_wr && (paddr == adc_out_pkg::OFS_CTRL)) begin
      ctrl_ff <= pwdata[2:0];
    end
  end

  property p_ctrl_write;
    @(posedge pclk) disable iff (!presetn)
      apb_wr && (paddr == adc_out_pkg::OFS_CTRL) |=> ctrl_ff == $past(pwdata[2:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write did not land");

  // A refused write must leave the control bits alone
  property p_bad_write;
    @(posedge pclk) disable iff (!presetn) apb_access && pwrite && !addr_ok |=> $stable(ctrl_ff);
  endproperty
  a_bad_write: assert property (p_bad_write) else $error("unmapped write changed control");

  // A new overrun in the clearing cycle keeps the flag set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_ff <= 1'b0;
    end else if (ovr_set) begin
      overrun_ff <= 1'b1;
    end else if (ovr_clr) begin
      overrun_ff <= 1'b0;
    end
  end

  property p_ovr_set_wins;
    @(posedge pclk) disable iff (!presetn) ovr_set |=> overrun_ff;
  endproperty
  a_ovr_set_wins: assert property (p_ovr_set_wins) else $error("overrun not recorded");

  property p_ovr_clear;
    @(posedge pclk) disable iff (!presetn) ovr_clr && !ovr_set |=> !overrun_ff;
  endproperty
  a_ovr_clear: assert property (p_ovr_clear) else $error("overrun not cleared by write one");

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_latency;
    @(posedge pclk) disable iff (!presetn)
      data_valid |-> data_out == {~$past(sample_in[9], 5), $past(sample_in[8:0], 5)};
  endproperty
  a_latency: assert property (p_latency) else $error("output word not the sample of five cycles before");

  property p_pos_fs;
    @(posedge pclk) disable iff (!presetn)
      (sample_in == adc_out_pkg::RAW_POS_FS) ##5 data_valid |-> data_out == adc_out_pkg::CODE_POS_FS;
  endproperty
  a_pos_fs: assert property (p_pos_fs) else $error("positive full scale not all ones");

  property p_neg_fs;
    @(posedge pclk) disable iff (!presetn)
      (sample_in == adc_out_pkg::RAW_NEG_FS) ##5 data_valid |-> data_out == adc_out_pkg::CODE_NEG_FS;
  endproperty
  a_neg_fs: assert property (p_neg_fs) else $error("negative full scale not all zeros");

  property p_mid;
    @(posedge pclk) disable iff (!presetn)
      (sample_in == adc_out_pkg::RAW_ZERO) ##5 data_valid |-> data_out == adc_out_pkg::CODE_MID;
  endproperty
  a_mid: assert property (p_mid) else $error("midscale word not msb only");

  property p_below_mid;
    @(posedge pclk) disable iff (!presetn)
      (sample_in == adc_out_pkg::RAW_MINUS1) ##5 data_valid |-> data_out == adc_out_pkg::CODE_MID_M1;
  endproperty
  a_below_mid: assert property (p_below_mid) else $error("one step below midscale wrong");

  property p_od_hiz;
    @(posedge pclk) disable iff (!presetn) output_disable |-> !data_out_en;
  endproperty
  a_od_hiz: assert property (p_od_hiz) else $error("pins driven while output disable high");

  property p_drive;
    @(posedge pclk) disable iff (!presetn)
      !output_disable && !power_down && ctrl_ff == adc_out_pkg::CTRL_RESET |-> data_out_en;
  endproperty
  a_drive: assert property (p_drive) else $error("pins floating in normal operation");

  property p_pd_hiz;
    @(posedge pclk) disable iff (!presetn) power_down |-> !data_out_en && low_power ##1 !data_valid;
  endproperty
  a_pd_hiz: assert property (p_pd_hiz) else $error("outputs active during power-down");

  property p_recovery_blank;
    @(posedge pclk) disable iff (!presetn) $fell(pd_act) |-> !data_valid [*5];
  endproperty
  a_recovery_blank: assert property (p_recovery_blank) else $error("valid word inside recovery window");

  property p_recovery_end;
    @(posedge pclk) disable iff (!presetn) $fell(pd_act) ##1 !pd_act [*5] |-> data_valid && !recovering;
  endproperty
  a_recovery_end: assert property (p_recovery_end) else $error("data not valid after recovery");

  property p_one_per_clock;
    @(posedge pclk) disable iff (!presetn)
      data_valid && $past(data_valid) |-> $past(pipe_ff[3]) == data_out;
  endproperty
  a_one_per_clock: assert property (p_one_per_clock) else $error("pipeline did not advance one word");

  property p_ctrl_pd;
    @(posedge pclk) disable iff (!presetn)
      ctrl_ff[adc_out_pkg::CTRL_PD_BIT] |-> !data_out_en && low_power ##1 !data_valid;
  endproperty
  a_ctrl_pd: assert property (p_ctrl_pd) else $error("outputs active during software power-down");

  property p_ctrl_od;
    @(posedge pclk) disable iff (!presetn) ctrl_ff[adc_out_pkg::CTRL_OD_BIT] |-> !data_out_en;
  endproperty
  a_ctrl_od: assert property (p_ctrl_od) else $error("pins driven while control disable set");

  // The status flag must end exactly where the invalid words end
  property p_rec_status;
    @(posedge pclk) disable iff (!presetn)
      $fell(pd_act) ##0 !pd_act [*6] |-> $past(recovering) && !recovering;
  endproperty
  a_rec_status: assert property (p_rec_status) else $error("recovering flag wrong length");
endmodule
`default_nettype wire

// File: hdl/adc_out_pkg.sv
// Constants shared by the converter output block and its capture FIFO
package adc_out_pkg;
  // ----------------------------------------------------------------
  // Word and pipeline shape
  // ----------------------------------------------------------------
  localparam int WORD_W = 10;
  localparam int LATENCY = 5;
  localparam int FIFO_DEPTH = 8;
  localparam logic [WORD_W-1:0] CODE_POS_FS = 10'h3ff;
  localparam logic [WORD_W-1:0] CODE_NEG_FS = 10'h000;
  localparam logic [WORD_W-1:0] CODE_MID = 10'h200;
  localparam logic [WORD_W-1:0] CODE_MID_M1 = 10'h1ff;
  localparam logic [WORD_W-1:0] RAW_POS_FS = 10'h1ff;
  localparam logic [WORD_W-1:0] RAW_NEG_FS = 10'h200;
  localparam logic [WORD_W-1:0] RAW_ZERO = 10'h000;
  localparam logic [WORD_W-1:0] RAW_MINUS1 = 10'h3ff;
  localparam logic [2:0] REC_CNT_INIT = 3'h5;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_DATA = 12'h008;
  localparam logic [11:0] OFS_LAST = 12'h00c;

  localparam int CTRL_OD_BIT = 0;
  localparam int CTRL_PD_BIT = 1;
  localparam int CTRL_CAP_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  localparam int ST_PD_BIT = 0;
  localparam int ST_REC_BIT = 1;
  localparam int ST_VALID_BIT = 2;
  localparam int ST_EMPTY_BIT = 3;
  localparam int ST_FULL_BIT = 4;
  localparam int ST_OVR_BIT = 5;
  localparam int DATA_VALID_BIT = 31;

  localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] WORD_RESET = 10'h000;
endpackage

// File: hdl/capture_fifo.sv
// Synchronous FIFO with valid/ready on both sides for captured words
`timescale 1ns/1ps
`default_nettype none
module capture_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  assign full = (count_ff == (AW+1)'(DEPTH));
  assign empty = (count_ff == '0);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  property p_no_overflow;
    @(posedge pclk) disable iff (!presetn) full && !pop |=> full;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("fifo lost fullness without a pop");
endmodule
`default_nettype wire

// File: bench/capture_model.sv
// Far-side capture logic that latches valid converter words
`timescale 1ns/1ps
`default_nettype none
module capture_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [adc_out_pkg::WORD_W-1:0] data_bus,
  input wire logic bus_driven,
  input wire logic data_valid,
  input wire logic power_down,
  output logic [adc_out_pkg::WORD_W-1:0] word_ff,
  output logic [15:0] count_ff
);
  logic [2:0] settle_ff;

  // ----------------------------------------------------------------
  // Own settle count: the device flag alone is not trusted
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_ff <= 3'h0;
    end else if (power_down) begin
      settle_ff <= adc_out_pkg::REC_CNT_INIT;
    end else if (settle_ff != 3'h0) begin
      settle_ff <= settle_ff - 3'h1;
    end
  end

  // One word per clock, kept as the sample five cycles back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_ff <= 10'h000;
      count_ff <= 16'h0000;
    end else if (!power_down && settle_ff == 3'h0 && bus_driven && data_valid) begin
      word_ff <= data_bus;
      count_ff <= count_ff + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// File: bench/adc_output_latency_powerdown_tb.sv
// Self-checking bench for the converter output block
`timescale 1ns/1ps
`default_nettype none
module adc_output_latency_powerdown_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:0] sample_in = 10'h000;
  logic output_disable = 1'b0;
  logic power_down = 1'b0;
  logic [9:0] data_out;
  logic data_out_en;
  logic data_valid;
  logic low_power;
  wire [9:0] data_bus;
  logic [9:0] cap_word;
  logic [15:0] cap_count;
  int err_count = 0;
  int checks = 0;
  logic [31:0] rd;
  logic er;

  // Undriven pins read as the inverse so a stale value never matches
  assign data_bus = data_out_en ? data_out : ~data_out;

  // One cycle stands for one conversion period; the model carries no absolute rate
  always #10 pclk = ~pclk;

  adc_output_latency_powerdown i_adc_output_latency_powerdown (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_in(sample_in), .output_disable(output_disable), .power_down(power_down),
    .data_out(data_out), .data_out_en(data_out_en), .data_valid(data_valid), .low_power(low_power));

  capture_model i_capture_model (.pclk(pclk), .presetn(presetn), .data_bus(data_bus), .bus_driven(data_out_en),
    .data_valid(data_valid), .power_down(power_down), .word_ff(cap_word), .count_ff(cap_count));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd, output logic [31:0] rdv,
                     output logic erv);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk("pready wait", 32'h0000_0001, 32'h0000_0000);
      final_report();
    end else begin
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic coding_stream();
    logic [9:0] raw[6] = '{10'h1ff, 10'h200, 10'h000, 10'h3ff, 10'h080, 10'h001};
    logic [9:0] exp[6] = '{10'h3ff, 10'h000, 10'h200, 10'h1ff, 10'h280, 10'h201};
    for (int j = 0; j < 11; j++) begin
      @(posedge pclk);
      if (j < 6) begin
        sample_in <= raw[j];
      end
      #1;
      if (j >= 5) begin
        chk("data_out", {22'h0, exp[j-5]}, {22'h0, data_out});
        chk("data_valid", 32'h1, {31'h0, data_valid});
      end
    end
    @(posedge pclk);
    #1;
    chk("capture word", {22'h0, exp[5]}, {22'h0, cap_word});
  endtask

  task automatic disable_pin();
    // Held high for a single clock, then dropped again while the stream runs
    @(posedge pclk);
    output_disable <= 1'b1;
    #1;
    chk("data_out_en od", 32'h0, {31'h0, data_out_en});
    @(posedge pclk);
    output_disable <= 1'b0;
    #1;
    chk("data_out_en drive", 32'h1, {31'h0, data_out_en});
    apb(1'b1, adc_out_pkg::OFS_CTRL, 32'h0000_0001, rd, er);
    #1;
    chk("data_out_en ctrl od", 32'h0, {31'h0, data_out_en});
    apb(1'b1, adc_out_pkg::OFS_CTRL, 32'h0000_0000, rd, er);
  endtask

  task automatic power_cycle();
    logic [15:0] cnt;
    @(posedge pclk);
    power_down <= 1'b1;
    #1;
    cnt = cap_count;
    chk("low_power", 32'h1, {31'h0, low_power});
    chk("data_out_en pd", 32'h0, {31'h0, data_out_en});
    repeat (4) @(posedge pclk);
    #1;
    chk("data_valid pd", 32'h0, {31'h0, data_valid});
    chk("capture pd", {16'h0, cnt}, {16'h0, cap_count});
    @(posedge pclk);
    power_down <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      #1;
      chk("data_valid recover", {31'h0, k == 5}, {31'h0, data_valid});
      if (k < 5) begin
        @(posedge pclk);
      end
    end
    chk("low_power off", 32'h0, {31'h0, low_power});
    apb(1'b1, adc_out_pkg::OFS_CTRL, 32'h0000_0002, rd, er);
    #1;
    chk("low_power ctrl", 32'h1, {31'h0, low_power});
    chk("data_out_en ctrl pd", 32'h0, {31'h0, data_out_en});
    apb(1'b1, adc_out_pkg::OFS_CTRL, 32'h0000_0000, rd, er);
    apb(1'b0, adc_out_pkg::OFS_STATUS, 32'h0, rd, er);
    chk("status recovering", 32'h0000_000a, rd & 32'h0000_003f);
  endtask

  task automatic fifo_regs();
    apb(1'b1, 12'h010, 32'h0000_0007, rd, er);
    chk("unmapped write err", 32'h1, {31'h0, er});
    apb(1'b0, adc_out_pkg::OFS_CTRL, 32'h0, rd, er);
    chk("ctrl reset", 32'h0, rd);
    chk("mapped err", 32'h0, {31'h0, er});
    apb(1'b0, 12'h010, 32'h0, rd, er);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    sample_in <= 10'h155;
    repeat (8) @(posedge pclk);
    apb(1'b1, adc_out_pkg::OFS_CTRL, 32'h0000_0004, rd, er);
    repeat (12) @(posedge pclk);
    apb(1'b1, adc_out_pkg::OFS_CTRL, 32'h0000_0000, rd, er);
    apb(1'b0, adc_out_pkg::OFS_STATUS, 32'h0, rd, er);
    chk("status full ovr", 32'h0000_0034, rd & 32'h0000_003f);
    for (int k = 0; k < 8; k++) begin
      apb(1'b0, adc_out_pkg::OFS_DATA, 32'h0, rd, er);
      chk("fifo word", 32'h8000_0355, rd);
      @(posedge pclk);
    end
    apb(1'b0, adc_out_pkg::OFS_DATA, 32'h0, rd, er);
    chk("fifo drained", 32'h0, {31'h0, rd[31]});
    apb(1'b0, adc_out_pkg::OFS_LAST, 32'h0, rd, er);
    chk("last word", 32'h0000_0355, rd);
    apb(1'b1, adc_out_pkg::OFS_STATUS, 32'h0000_0020, rd, er);
    apb(1'b0, adc_out_pkg::OFS_STATUS, 32'h0, rd, er);
    chk("status empty", 32'h0000_000c, rd & 32'h0000_003f);
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk("low_power reset", 32'h0, {31'h0, low_power});
    coding_stream();
    disable_pin();
    power_cycle();
    fifo_regs();
    final_report();
  end
endmodule
`default_nettype wire
